// ===== src/uart_flow_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "flow_ctrl_regs.vh"
module uart_flow_ctrl #(
  parameter HAS_HANDSHAKE = 1,
  parameter LVL_W = 11,
  parameter CYC_W = 16,
  parameter BIT_CYCLES = 16'h00d9
) (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // handshake pins
  input wire cts_pin,
  output reg rts_out,
  output wire rts_oe,
  // receive fifo side
  input wire rx_push,
  input wire rx_pop,
  input wire [LVL_W-1:0] rx_level,
  // transmit side
  input wire tx_pending,
  input wire tx_line_idle,
  output wire tx_start,
  // interrupt conditions
  output reg irq_data,
  output reg irq_timeout,
  output reg irq_modem
);
  reg [31:0] ctrl;
  reg cts_prev;
  reg modem_flag;
  wire cts_sync;
  wire cts_asserted;
  wire hs_on;
  wire wr_en;
  wire rd_en;
  wire rx_trig_hit;
  wire auto_hit;
  wire tmo_expired;
  reg [LVL_W-1:0] rx_trig;
  reg [LVL_W-1:0] auto_trig;
  reg next_rts;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;

  // handshake exists only on the first port
  assign hs_on = (HAS_HANDSHAKE != 0) & ctrl[`CTRL_ENABLE];
  assign rts_oe = hs_on;

  sync_two_flop u_cts_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(cts_pin),
    .sync_out(cts_sync)
  );

  // polarity applied after the synchroniser
  assign cts_asserted = cts_sync ^ ctrl[`CTRL_CTS_LOW];

  // without auto gating software decides when data is written
  assign tx_start = tx_pending & tx_line_idle & ctrl[`CTRL_ENABLE] &
    (~(hs_on & ctrl[`CTRL_AUTO_CTS]) | cts_asserted);

  always @* begin
    case (ctrl[`CTRL_RX_TRIG_LSB+1:`CTRL_RX_TRIG_LSB])
      2'b00: rx_trig = {{(LVL_W-4){1'b0}}, 4'h1};
      2'b01: rx_trig = {{(LVL_W-4){1'b0}}, 4'h4};
      2'b10: rx_trig = {{(LVL_W-4){1'b0}}, 4'h8};
      default: rx_trig = {{(LVL_W-4){1'b0}}, 4'he};
    endcase
  end

  always @* begin
    case (ctrl[`CTRL_AUTO_TRIG_LSB+1:`CTRL_AUTO_TRIG_LSB])
      2'b00: auto_trig = {{(LVL_W-4){1'b0}}, 4'h8};
      2'b01: auto_trig = {{(LVL_W-4){1'b0}}, 4'hb};
      2'b10: auto_trig = {{(LVL_W-4){1'b0}}, 4'hd};
      default: auto_trig = {{(LVL_W-4){1'b0}}, 4'hf};
    endcase
  end

  assign rx_trig_hit = rx_level >= rx_trig;
  assign auto_hit = rx_level >= auto_trig;

  // request level before polarity
  always @* begin
    if (ctrl[`CTRL_AUTO_RTS]) begin
      next_rts = ~auto_hit;
    end else begin
      next_rts = ctrl[`CTRL_RTS_MANUAL];
    end
  end

  char_timer #(
    .CYC_W(CYC_W),
    .CNT_W(24)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .bit_cycles(BIT_CYCLES),
    .restart(rx_push | rx_pop),
    .armed(rx_level != 0),
    .expired(tmo_expired)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET;
      rts_out <= 1'b0;
      cts_prev <= 1'b0;
      modem_flag <= 1'b0;
      irq_data <= 1'b0;
      irq_timeout <= 1'b0;
      irq_modem <= 1'b0;
    end else begin
      if (wr_en && paddr == `CTRL_OFFSET) begin
        ctrl <= {20'h0, pwdata[11:0]};
      end
      rts_out <= hs_on & (next_rts ^ ctrl[`CTRL_RTS_LOW]);
      cts_prev <= cts_asserted;
      // set wins over a write clear
      if (hs_on && cts_prev != cts_asserted) begin
        modem_flag <= 1'b1;
      end else if (wr_en && paddr == `IRQ_OFFSET && pwdata[2]) begin
        modem_flag <= 1'b0;
      end
      irq_modem <= modem_flag & ctrl[`CTRL_IE_MODEM];
      irq_data <= rx_trig_hit & ctrl[`CTRL_IE_DATA];
      irq_timeout <= tmo_expired & ctrl[`CTRL_IE_DATA];
    end
  end

  // fifo fill is fed by the receive path itself
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      if (paddr == `CTRL_OFFSET) begin
        prdata <= ctrl;
      end else if (paddr == `STAT_OFFSET) begin
        prdata <= {29'h0, modem_flag, rts_out, cts_asserted};
      end else if (paddr == `RXLVL_OFFSET) begin
        prdata <= {{(32-LVL_W){1'b0}}, rx_level};
      end else if (paddr == `IRQ_OFFSET) begin
        prdata <= {29'h0, irq_modem, irq_timeout, irq_data};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/flow_ctrl_regs.vh
// Notes on behaviour
// - send only while partner signals ready
// - asserted clear input means remote ready
// - clear change raises modem irq; level readable
// - head byte starts when line idle
// - manual mode: request pin follows control bit
// - received characters enter receive fifo automatically
// - data irq at level 1,4,8,14
// - data irq enable also enables timeout
// - auto trigger 8,11,13,15 bytes
// - auto: request asserted below trigger
// - auto: request dropped at or above trigger
// - auto clear gating: send only when asserted
// - request and clear polarity configurable
// - auto receive and transmit enabled separately
// - first port owns handshake pins when enabled
// - second port has no handshake
// - receive fifo level readable anytime
// - data irq clears below trigger
// - timeout after four idle character times
// - reading a character clears timeout, restarts
`ifndef FLOW_CTRL_REGS_VH
`define FLOW_CTRL_REGS_VH
`define CTRL_OFFSET 12'h000
`define STAT_OFFSET 12'h004
`define RXLVL_OFFSET 12'h008
`define IRQ_OFFSET 12'h00c
`define CTRL_ENABLE 0
`define CTRL_RTS_MANUAL 1
`define CTRL_AUTO_RTS 2
`define CTRL_AUTO_CTS 3
`define CTRL_RTS_LOW 4
`define CTRL_CTS_LOW 5
`define CTRL_AUTO_TRIG_LSB 6
`define CTRL_RX_TRIG_LSB 8
`define CTRL_IE_DATA 10
`define CTRL_IE_MODEM 11
`define CTRL_RESET 32'h0000_0000
`define CHAR_BITS 10
`define TIMEOUT_CHARS 4
`endif

// ===== src/sync_two_flop.v
`timescale 1ns/1ps
`default_nettype none
module sync_two_flop (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // async level in, synced level out
  input wire async_in,
  output reg sync_out
);
  reg stage_one;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_one <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule
`default_nettype wire

// ===== src/char_timer.v
`timescale 1ns/1ps
`default_nettype none
// counts idle character times; restart clears it
module char_timer #(
  parameter CYC_W = 16,
  parameter CNT_W = 24
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // timing
  input wire [CYC_W-1:0] bit_cycles,
  input wire restart,
  input wire armed,
  output reg expired
);
  reg [CNT_W-1:0] count;
  wire [CNT_W-1:0] limit;
  wire [31:0] limit_full;
  // product is 32 bits wide; the counter width bounds the longest timeout
  assign limit_full = bit_cycles * `CHAR_BITS * `TIMEOUT_CHARS;
  assign limit = limit_full[CNT_W-1:0];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= {CNT_W{1'b0}};
      expired <= 1'b0;
    end else if (restart || !armed) begin
      count <= {CNT_W{1'b0}};
      expired <= 1'b0;
    end else if (count >= limit) begin
      expired <= 1'b1;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== verification/remote_uart.sv
`timescale 1ns/1ps
`default_nettype none
module remote_uart (
  // far end wish and pins
  input wire logic ready,
  input wire logic rts_out,
  input wire logic rts_oe,
  output logic cts_pin,
  output logic may_send
);
  assign cts_pin = ready;
  // a released pin never counts as a go-ahead
  assign may_send = rts_oe && rts_out;
endmodule
`default_nettype wire

// ===== verification/fc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fc_checker (
  // bus and pins
  input wire logic pclk, presetn, psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic cts_pin, rts_out, rts_oe, tx_pending, tx_line_idle, tx_start,
  input wire logic irq_data, irq_modem,
  input wire logic [10:0] rx_level
);
  logic [31:0] c;
  wire [4:0] at = c[7] ? (c[6] ? 5'h0f : 5'h0d) : (c[6] ? 5'h0b : 5'h08);
  wire [4:0] dt = c[9] ? (c[8] ? 5'h0e : 5'h08) : (c[8] ? 5'h04 : 5'h01);
  wire man = c[1] ^ c[4];
  wire aut = (rx_level < {6'h00, at}) ^ c[4];
  wire full = rx_level >= {6'h00, dt};
  // shadow of the control word, so no internal probe is needed
  always @(posedge pclk or negedge presetn)
    if (!presetn) c <= 32'h0;
    else if (psel && penable && pwrite && paddr == 12'h000) c <= pwdata;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence cts_edge;
    $past(cts_pin, 2) != $past(cts_pin, 3);
  endsequence
  a_pin_owner:
    assert property (rts_oe == c[0]) else $error("pin owner");
  a_rts_manual:
    assert property (c[0] && !c[2] |=> rts_out == $past(man)) else $error("manual rts");
  a_rts_auto:
    assert property (c[0] && c[2] |=> rts_out == $past(aut)) else $error("auto rts");
  a_tx_idle:
    assert property (tx_start |-> tx_pending && tx_line_idle) else $error("tx start");
  a_tx_gated:
    assert property (c[3] && tx_start |-> $past(cts_pin, 2) ^ c[5]) else $error("tx gate");
  a_tx_free:
    assert property (c[0] && !c[3] && tx_pending && tx_line_idle |-> tx_start)
      else $error("tx free");
  a_modem_irq:
    assert property (cts_edge ##0 c[0] && c[11] |-> ##[0:4] irq_modem) else $error("modem");
  a_data_irq:
    assert property (c[0] && c[10] |=> irq_data == $past(full)) else $error("data irq");
endmodule
bind uart_flow_ctrl fc_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .cts_pin, .rts_out, .rts_oe, .tx_pending, .tx_line_idle, .tx_start,
  .irq_data, .irq_modem, .rx_level);
`default_nettype wire

// ===== verification/uart_flow_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uart_flow_ctrl_tb;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic rx_push = 1'h0, rx_pop = 1'h0, tx_pending = 1'h0, tx_line_idle = 1'h0, ready = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rdat;
  logic [10:0] rx_level = 11'h0;
  logic [10:0] at [4] = '{11'h8, 11'hb, 11'hd, 11'hf};
  logic [10:0] dt [4] = '{11'h1, 11'h4, 11'h8, 11'he};
  wire [31:0] prdata;
  wire pready, pslverr, cts_pin, rts_out, rts_oe, tx_start, may_send;
  wire irq_data, irq_timeout, irq_modem;
  int fails = 0, cmp_count = 0, cyc = 0, i;
  // short bit time keeps the idle timeout at tens of cycles
  uart_flow_ctrl #(.BIT_CYCLES(16'h0002)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .cts_pin, .rts_out, .rts_oe, .rx_push,
    .rx_pop, .rx_level, .tx_pending, .tx_line_idle, .tx_start, .irq_data, .irq_timeout,
    .irq_modem);
  remote_uart far (.ready, .rts_out, .rts_oe, .cts_pin, .may_send);
  initial forever #20 pclk = ~pclk;
  task automatic conclude;
    $display("compared %0d failed %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      conclude;
    end
  end
  task automatic chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, wr, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rdat = prdata;
    {psel, penable} <= 2'h0;
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge pclk);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    bus(1'h0, 12'h000, 32'h0);
    chk(rdat, 32'h0);
    bus(1'h0, 12'h010, 32'h0);
    chk(rdat, 32'h0);
    bus(1'h1, 12'h000, 32'h3);
    w(2);
    chk(may_send, 32'h1);
    bus(1'h1, 12'h000, 32'h13);
    w(2);
    chk(rts_out, 32'h0);
    $display("manual done");
    for (i = 0; i < 4; i++) begin
      bus(1'h1, 12'h000, 32'h405 | i << 6 | i << 8);
      @(posedge pclk) rx_level <= at[i] - 11'h1;
      w(2);
      chk(rts_out, 32'h1);
      @(posedge pclk) rx_level <= at[i];
      w(2);
      chk(rts_out, 32'h0);
      bus(1'h0, 12'h008, 32'h0);
      chk(rdat, {21'h0, at[i]});
      @(posedge pclk) rx_level <= dt[i] - 11'h1;
      w(2);
      chk(irq_data, 32'h0);
      @(posedge pclk) rx_level <= dt[i];
      w(2);
      chk(irq_data, 32'h1);
    end
    $display("levels done");
    bus(1'h1, 12'h000, 32'h501);
    @(posedge pclk) {rx_level, rx_push} <= {11'h1, 1'h1};
    @(posedge pclk) rx_push <= 1'h0;
    w(60);
    chk(irq_timeout, 32'h0);
    w(70);
    chk(irq_timeout, 32'h1);
    @(posedge pclk) rx_pop <= 1'h1;
    @(posedge pclk) rx_pop <= 1'h0;
    w(60);
    chk(irq_timeout, 32'h0);
    $display("timeout done");
    bus(1'h1, 12'h000, 32'h9);
    @(posedge pclk) {tx_pending, tx_line_idle} <= 2'h3;
    w(5);
    chk(tx_start, 32'h0);
    @(posedge pclk) ready <= 1'h1;
    w(5);
    chk(tx_start, 32'h1);
    bus(1'h0, 12'h004, 32'h0);
    chk(rdat[0], 32'h1);
    @(posedge pclk) tx_line_idle <= 1'h0;
    w(1);
    chk(tx_start, 32'h0);
    bus(1'h1, 12'h00c, 32'h4);
    bus(1'h1, 12'h000, 32'h801);
    w(2);
    chk(irq_modem, 32'h0);
    @(posedge pclk) {ready, tx_line_idle} <= 2'h1;
    w(6);
    chk(irq_modem, 32'h1);
    chk(tx_start, 32'h1);
    bus(1'h1, 12'h00c, 32'h4);
    w(2);
    chk(irq_modem, 32'h0);
    $display("transmit done");
    conclude;
  end
endmodule
`default_nettype wire
